// ### rtl/tcc_pkg.sv
/*
 * package of the timer compare output control block: register offsets,
 * field positions, reset values and waveform mode codes.
 * assumes an 8-bit cpu i/o bus with byte-wide registers at private offsets.
 */
package tcc_pkg;

	localparam logic [2:0] OFS_CTRL_A     = 3'h0;
	localparam logic [2:0] OFS_FORCE      = 3'h1;
	localparam logic [2:0] OFS_PIN_EN     = 3'h2;
	localparam logic [2:0] OFS_CNT_LO     = 3'h3;
	localparam logic [2:0] OFS_CNT_HI     = 3'h4;
	localparam logic [2:0] OFS_CMP_A_LO   = 3'h5;
	localparam logic [2:0] OFS_CMP_B_LO   = 3'h6;
	localparam logic [2:0] OFS_CMP_HI     = 3'h7;

	localparam int POS_MODE_A = 6;
	localparam int POS_MODE_B = 4;
	localparam int POS_WGM_LO = 0;
	localparam int POS_FORCE_A = 7;
	localparam int POS_FORCE_B = 6;

	localparam logic [7:0]  RST_CTRL_A = 8'h00;
	localparam logic [7:0]  RST_PIN_EN = 8'h00;
	localparam logic [15:0] RST_CNT    = 16'h0000;
	localparam logic [15:0] RST_CMP    = 16'hFFFF;
	localparam logic [7:0]  CTRL_A_WMASK = 8'hF3;

	localparam logic [1:0] COM_OFF    = 2'h0;
	localparam logic [1:0] COM_TOGGLE = 2'h1;
	localparam logic [1:0] COM_CLEAR  = 2'h2;
	localparam logic [1:0] COM_SET    = 2'h3;

	typedef enum logic [1:0] {
		TCC_NORMAL,
		TCC_CTC,
		TCC_FAST_PWM,
		TCC_OTHER_PWM
	} tcc_wave_kind_t;

endpackage

// ### rtl/tcc_out_chan.sv
/*
 * one compare output channel: waveform flop and match/top actions.
 * assumes match, top and force strobes are one-cycle pulses on clock.
 */
`timescale 1ns/1ps
module tcc_out_chan (
	input  wire logic                    clock,
	input  wire logic                    rst,
	input  wire logic [1:0]              out_mode,
	input  wire tcc_pkg::tcc_wave_kind_t kind,
	input  wire logic                    top_bit,
	input  wire logic                    is_chan_a,
	input  wire logic                    match,
	input  wire logic                    cmp_eq_top,
	input  wire logic                    at_top,
	input  wire logic                    force_hit,
	output logic                         wave_ff,
	output logic                         connected
);
	import tcc_pkg::*;

	logic nxt_wave;
	logic pwm;
	logic eff_match;
	logic fast;

	assign pwm  = (kind == TCC_FAST_PWM) || (kind == TCC_OTHER_PWM);
	assign fast = (kind == TCC_FAST_PWM);
	// compare match at top is dropped in fast pwm when mode high bit set
	assign eff_match = (match && !(fast && out_mode[1] && cmp_eq_top)) // [RULE7]
		|| (force_hit && !pwm); // [RULE8] [RULE9]
	// toggle in fast pwm only for channel a with top bit set
	assign connected = (out_mode != COM_OFF)
		&& !(fast && out_mode == COM_TOGGLE && !(top_bit && is_chan_a)); // [RULE4]

	always_comb begin
		nxt_wave = wave_ff;
		if (fast) begin
			unique case (out_mode)
				COM_TOGGLE: if (eff_match && top_bit && is_chan_a) nxt_wave = ~wave_ff; // [RULE4]
				COM_CLEAR: begin
					if (eff_match) nxt_wave = 1'b0; // [RULE5]
					if (at_top) nxt_wave = 1'b1;
				end
				COM_SET: begin
					if (eff_match) nxt_wave = 1'b1; // [RULE6]
					if (at_top) nxt_wave = 1'b0;
				end
				COM_OFF: nxt_wave = wave_ff;
			endcase
		end else if (eff_match) begin
			unique case (out_mode)
				COM_TOGGLE: nxt_wave = ~wave_ff; // [RULE3]
				COM_CLEAR:  nxt_wave = 1'b0;
				COM_SET:    nxt_wave = 1'b1;
				COM_OFF:    nxt_wave = wave_ff;
			endcase
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) wave_ff <= 1'b0;
		else wave_ff <= nxt_wave;
	end
endmodule

// ### rtl/tcc_pin_mux.sv
/*
 * one port pin: selects compare output or port data and drive enable.
 * assumes port data and direction come from the port logic on clock.
 */
`timescale 1ns/1ps
module tcc_pin_mux (
	input  wire logic clock,
	input  wire logic rst,
	input  wire logic connected,
	input  wire logic pin_en,
	input  wire logic wave,
	input  wire logic port_data,
	input  wire logic port_dir,
	output logic      pin_out_ff,
	output logic      pin_oe_ff
);
	logic take;
	logic nxt_out;
	logic nxt_oe;

	assign take    = connected && pin_en; // [RULE1] [RULE2]
	assign nxt_out = take ? wave : port_data;
	assign nxt_oe  = port_dir && (take || !pin_en || !connected); // [RULE1]

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pin_out_ff <= 1'b0;
			pin_oe_ff  <= 1'b0;
		end else begin
			pin_out_ff <= nxt_out;
			pin_oe_ff  <= nxt_oe;
		end
	end
endmodule

// ### rtl/tcc_timer.sv
/*
 * 16-bit timer compare output control: registers, counter, shared high byte
 * latch, compare units and pin steering for two channels of four pins each.
 * assumes a single-cycle cpu i/o bus on clock and port pins outside.
 */
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////
// Operation
// (RULE1) active compare mode overrides port; driver needs direction and pin enable
// (RULE2) pin enable zero keeps normal port operation on that pin
// (RULE3) non-pwm codes: off, toggle, clear, set on match
// (RULE4) fast pwm code 01: off unless top bit; then channel a toggles
// (RULE5) fast pwm code 10 clears on match, sets at top
// (RULE6) fast pwm code 11 sets on match, clears at top
// (RULE7) fast pwm: match at top ignored when mode high bit set
// (RULE8) force strobes act only in non-pwm modes; software writes zero otherwise
// (RULE9) force strobe applies one match action immediately
// (RULE10) force raises no flag and never clears the counter
// (RULE11) force bits always read zero
// (RULE12) pin enable register: bits 7:4 channel b, 3:0 channel a, reset zero
// (RULE13) counter bytes move through one shared 8-bit high byte latch
// (RULE14) counter write blocks compare match for the next timer clock
// (RULE15) software writes high byte first and reads low byte first
module tcc_timer (
	input  wire logic       clock,
	input  wire logic       rst,
	input  wire logic [2:0] bus_addr,
	input  wire logic       bus_wr,
	input  wire logic       bus_rd,
	input  wire logic [7:0] bus_wdata,
	input  wire logic [1:0] wave_gen_hi,
	input  wire logic       timer_tick,
	input  wire logic [7:0] port_data,
	input  wire logic [7:0] port_dir,
	output logic [7:0]      bus_rdata_ff,
	output logic [3:0]      pin_a_out_ff,
	output logic [3:0]      pin_a_oe_ff,
	output logic [3:0]      pin_b_out_ff,
	output logic [3:0]      pin_b_oe_ff,
	output logic            match_a_flag_ff,
	output logic            match_b_flag_ff,
	output logic            wave_out_a_ff,
	output logic            wave_out_b_ff
);
	import tcc_pkg::*;

	logic [7:0]     timer_ctrl_a_ff;
	logic [7:0]     compare_pin_enables_ff;
	logic [15:0]    counter_value_ff;
	logic [15:0]    compare_reg_a_ff;
	logic [15:0]    compare_reg_b_ff;
	logic [7:0]     temp_high_ff;
	logic           block_match_ff;
	logic [1:0]     tick_sync_ff;
	logic           tick_prev_ff;
	logic [3:0]     waveform_gen_select;
	logic [1:0]     chan_a_out_mode;
	logic [1:0]     chan_b_out_mode;
	logic [3:0]     chan_a_pin_enables;
	logic [3:0]     chan_b_pin_enables;
	logic           waveform_gen_top_bit;
	tcc_wave_kind_t kind;
	logic [15:0]    top_value;
	logic           at_top;
	logic           tick;
	logic           wr_ctrl;
	logic           wr_force;
	logic           wr_pin;
	logic           wr_lo;
	logic           wr_hi;
	logic           wr_cmp_a;
	logic           wr_cmp_b;
	logic           rd_lo;
	logic           force_match_a;
	logic           force_match_b;
	logic           match_a;
	logic           match_b;
	logic           ctc_clear;
	logic [15:0]    nxt_counter;
	logic [7:0]     nxt_rdata;
	logic           wave_a;
	logic           wave_b;
	logic           conn_a;
	logic           conn_b;
	logic           cmp_a_eq_top;
	logic           cmp_b_eq_top;
	logic           cnt_wrap;
	logic [15:0]    cnt_inc;
	logic [15:0]    wide_wdata;
	logic [7:0]     ctrl_wdata;
	logic [3:0]     port_data_a;
	logic [3:0]     port_data_b;
	logic [3:0]     port_dir_a;
	logic [3:0]     port_dir_b;

	//////////////////////////////////////////////////////////////////////////
	// register decode

	assign wr_ctrl  = bus_wr && (bus_addr == OFS_CTRL_A);
	assign wr_force = bus_wr && (bus_addr == OFS_FORCE);
	assign wr_pin   = bus_wr && (bus_addr == OFS_PIN_EN);
	assign wr_lo    = bus_wr && (bus_addr == OFS_CNT_LO);
	assign wr_hi    = bus_wr && ((bus_addr == OFS_CNT_HI) || (bus_addr == OFS_CMP_HI));
	assign wr_cmp_a = bus_wr && (bus_addr == OFS_CMP_A_LO);
	assign wr_cmp_b = bus_wr && (bus_addr == OFS_CMP_B_LO);
	assign rd_lo    = bus_rd && (bus_addr == OFS_CNT_LO);

	assign wide_wdata = {temp_high_ff, bus_wdata}; // [RULE13]
	assign ctrl_wdata = bus_wdata & CTRL_A_WMASK;

	assign chan_a_out_mode      = timer_ctrl_a_ff[POS_MODE_A +: 2];
	assign chan_b_out_mode      = timer_ctrl_a_ff[POS_MODE_B +: 2];
	assign waveform_gen_select  = {wave_gen_hi, timer_ctrl_a_ff[POS_WGM_LO +: 2]};
	assign waveform_gen_top_bit = waveform_gen_select[3];
	assign chan_a_pin_enables   = compare_pin_enables_ff[3:0]; // [RULE12]
	assign chan_b_pin_enables   = compare_pin_enables_ff[7:4]; // [RULE12]

	// force bits are strobes, never stored
	assign force_match_a = wr_force && bus_wdata[POS_FORCE_A]; // [RULE9]
	assign force_match_b = wr_force && bus_wdata[POS_FORCE_B];

	//////////////////////////////////////////////////////////////////////////
	// waveform mode and top

	always_comb begin
		kind      = TCC_OTHER_PWM;
		top_value = 16'hFFFF;
		unique case (waveform_gen_select)
			4'h0: kind = TCC_NORMAL;
			4'h4: begin
				kind      = TCC_CTC;
				top_value = compare_reg_a_ff;
			end
			4'hC: kind = TCC_CTC;
			4'h5: begin
				kind      = TCC_FAST_PWM;
				top_value = 16'h00FF;
			end
			4'h6: begin
				kind      = TCC_FAST_PWM;
				top_value = 16'h01FF;
			end
			4'h7: begin
				kind      = TCC_FAST_PWM;
				top_value = 16'h03FF;
			end
			4'hF: begin
				kind      = TCC_FAST_PWM;
				top_value = compare_reg_a_ff;
			end
			default: kind = TCC_OTHER_PWM;
		endcase
	end

	//////////////////////////////////////////////////////////////////////////
	// counter and compare

	assign tick    = tick_sync_ff[1] && !tick_prev_ff;
	assign at_top  = tick && (counter_value_ff == top_value);
	// compare unit blocked on the timer clock after a counter write
	assign match_a = tick && !block_match_ff && (counter_value_ff == compare_reg_a_ff); // [RULE14]
	assign match_b = tick && !block_match_ff && (counter_value_ff == compare_reg_b_ff); // [RULE14]
	// in ctc a real match or reaching the top value clears the counter, never a forced match
	assign ctc_clear = (kind == TCC_CTC) && match_a; // [RULE10]
	assign cnt_wrap  = at_top || ctc_clear;
	assign cnt_inc   = counter_value_ff + 16'h0001;
	assign cmp_a_eq_top = (compare_reg_a_ff == top_value); // [RULE7]
	assign cmp_b_eq_top = (compare_reg_b_ff == top_value); // [RULE7]

	always_comb begin
		nxt_counter = counter_value_ff;
		if (wr_lo) begin
			nxt_counter = wide_wdata; // [RULE13]
		end else if (tick) begin
			if (cnt_wrap) nxt_counter = RST_CNT;
			else nxt_counter = cnt_inc;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// read mux

	always_comb begin
		nxt_rdata = 8'h00;
		unique case (bus_addr)
			OFS_CTRL_A:   nxt_rdata = timer_ctrl_a_ff;
			OFS_FORCE:    nxt_rdata = 8'h00; // [RULE11]
			OFS_PIN_EN:   nxt_rdata = compare_pin_enables_ff;
			OFS_CNT_LO:   nxt_rdata = counter_value_ff[7:0];
			OFS_CNT_HI:   nxt_rdata = temp_high_ff; // [RULE13]
			OFS_CMP_A_LO: nxt_rdata = compare_reg_a_ff[7:0];
			OFS_CMP_B_LO: nxt_rdata = compare_reg_b_ff[7:0];
			OFS_CMP_HI:   nxt_rdata = temp_high_ff;
		endcase
		if (!bus_rd) nxt_rdata = 8'h00;
	end

	//////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			timer_ctrl_a_ff        <= RST_CTRL_A;
			compare_pin_enables_ff <= RST_PIN_EN; // [RULE12]
		end else begin
			if (wr_ctrl) timer_ctrl_a_ff <= ctrl_wdata;
			if (wr_pin) compare_pin_enables_ff <= bus_wdata;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) counter_value_ff <= RST_CNT;
		else counter_value_ff <= nxt_counter;
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			compare_reg_a_ff <= RST_CMP;
			compare_reg_b_ff <= RST_CMP;
		end else begin
			if (wr_cmp_a) compare_reg_a_ff <= wide_wdata;
			if (wr_cmp_b) compare_reg_b_ff <= wide_wdata;
		end
	end

	// one shared latch: high writes park here, counter low reads fill it
	always_ff @(posedge clock or posedge rst) begin
		if (rst) temp_high_ff <= 8'h00;
		else if (wr_hi) temp_high_ff <= bus_wdata; // [RULE13]
		else if (rd_lo) temp_high_ff <= counter_value_ff[15:8]; // [RULE13]
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) block_match_ff <= 1'b0;
		else if (wr_lo) block_match_ff <= 1'b1; // [RULE14]
		else if (tick) block_match_ff <= 1'b0;
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) bus_rdata_ff <= 8'h00;
		else bus_rdata_ff <= nxt_rdata;
	end

	// tick pin synchroniser and edge detect
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			tick_sync_ff <= 2'b00;
			tick_prev_ff <= 1'b0;
		end else begin
			tick_sync_ff <= {tick_sync_ff[0], timer_tick};
			tick_prev_ff <= tick_sync_ff[1];
		end
	end

	// flags set only by real matches, forces excluded
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			match_a_flag_ff <= 1'b0;
			match_b_flag_ff <= 1'b0;
		end else begin
			match_a_flag_ff <= match_a; // [RULE10]
			match_b_flag_ff <= match_b;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// channels and pins

	tcc_out_chan u_chan_a (
		.clock      (clock),
		.rst        (rst),
		.out_mode   (chan_a_out_mode),
		.kind       (kind),
		.top_bit    (waveform_gen_top_bit),
		.is_chan_a  (1'b1),
		.match      (match_a),
		.cmp_eq_top (cmp_a_eq_top),
		.at_top     (at_top),
		.force_hit  (force_match_a),
		.wave_ff    (wave_a),
		.connected  (conn_a)
	);

	tcc_out_chan u_chan_b (
		.clock      (clock),
		.rst        (rst),
		.out_mode   (chan_b_out_mode),
		.kind       (kind),
		.top_bit    (waveform_gen_top_bit),
		.is_chan_a  (1'b0),
		.match      (match_b),
		.cmp_eq_top (cmp_b_eq_top),
		.at_top     (at_top),
		.force_hit  (force_match_b),
		.wave_ff    (wave_b),
		.connected  (conn_b)
	);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wave_out_a_ff <= 1'b0;
			wave_out_b_ff <= 1'b0;
		end else begin
			wave_out_a_ff <= wave_a;
			wave_out_b_ff <= wave_b;
		end
	end

	assign port_data_a = port_data[3:0];
	assign port_data_b = port_data[7:4];
	assign port_dir_a  = port_dir[3:0];
	assign port_dir_b  = port_dir[7:4];

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_pin
			tcc_pin_mux u_pin_a (
				.clock      (clock),
				.rst        (rst),
				.connected  (conn_a),
				.pin_en     (chan_a_pin_enables[gi]),
				.wave       (wave_a),
				.port_data  (port_data_a[gi]),
				.port_dir   (port_dir_a[gi]),
				.pin_out_ff (pin_a_out_ff[gi]),
				.pin_oe_ff  (pin_a_oe_ff[gi])
			);
			tcc_pin_mux u_pin_b (
				.clock      (clock),
				.rst        (rst),
				.connected  (conn_b),
				.pin_en     (chan_b_pin_enables[gi]),
				.wave       (wave_b),
				.port_data  (port_data_b[gi]),
				.port_dir   (port_dir_b[gi]),
				.pin_out_ff (pin_b_out_ff[gi]),
				.pin_oe_ff  (pin_b_oe_ff[gi])
			);
		end
	endgenerate
endmodule

// ### testbench/tcc_timer_properties.sv
/*
 * checker of the timer compare output control block, with its bind.
 * assumes it sees only the ports of tcc_timer, one clock, async reset.
 */
`timescale 1ns/1ps
module tcc_timer_properties (
	input wire logic       clock,
	input wire logic       rst,
	input wire logic [2:0] bus_addr,
	input wire logic       bus_wr,
	input wire logic       bus_rd,
	input wire logic [7:0] bus_wdata,
	input wire logic [1:0] wave_gen_hi,
	input wire logic       timer_tick,
	input wire logic [7:0] port_data,
	input wire logic [7:0] port_dir,
	input wire logic [7:0] bus_rdata_ff,
	input wire logic [3:0] pin_a_out_ff,
	input wire logic [3:0] pin_a_oe_ff,
	input wire logic [3:0] pin_b_out_ff,
	input wire logic [3:0] pin_b_oe_ff,
	input wire logic       match_a_flag_ff,
	input wire logic       match_b_flag_ff,
	input wire logic       wave_out_a_ff,
	input wire logic       wave_out_b_ff
);
	import tcc_pkg::*;
	logic [7:0] ctrl_sh_ff;
	logic [7:0] pin_sh_ff;
	logic [3:0] tick_age_ff;
	logic [3:0] frc_age_ff;
	wire logic       frc_wr  = bus_wr && bus_addr == OFS_FORCE;
	wire logic [3:0] wgm     = {wave_gen_hi, ctrl_sh_ff[1:0]};
	wire logic       non_pwm = wgm == 4'h0 || wgm == 4'h4 || wgm == 4'hC;

	////////////////////////////////////////////////////////////////////////////
	// shadows of the writable fields, ages since a tick and a force
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ctrl_sh_ff <= RST_CTRL_A;
			pin_sh_ff <= RST_PIN_EN;
			tick_age_ff <= 4'hF;
			frc_age_ff <= 4'hF;
		end else begin
			if (bus_wr && bus_addr == OFS_CTRL_A) ctrl_sh_ff <= bus_wdata & CTRL_A_WMASK;
			if (bus_wr && bus_addr == OFS_PIN_EN) pin_sh_ff <= bus_wdata;
			tick_age_ff <= timer_tick ? 4'h0 : tick_age_ff + {3'h0, tick_age_ff != 4'hF};
			frc_age_ff <= frc_wr ? 4'h0 : frc_age_ff + {3'h0, frc_age_ff != 4'hF};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	a_force_reads_zero: assert property (
		bus_rd && bus_addr == OFS_FORCE |=> bus_rdata_ff == 8'h00)
		else $error("force offset read nonzero");
	a_pin_oe_dir: assert property (
		!$past(rst) |-> {pin_b_oe_ff, pin_a_oe_ff} == $past(port_dir))
		else $error("pin drive enable differs from direction");
	a_pin_a_port: assert property (
		!$past(rst) |-> ((pin_a_out_ff ^ $past(port_data[3:0])) & ~$past(pin_sh_ff[3:0])) == 4'h0)
		else $error("disabled a pin lost port data");
	a_pin_b_port: assert property (
		!$past(rst) |-> ((pin_b_out_ff ^ $past(port_data[7:4])) & ~$past(pin_sh_ff[7:4])) == 4'h0)
		else $error("disabled b pin lost port data");
	a_flag_from_tick: assert property (
		match_a_flag_ff || match_b_flag_ff |-> tick_age_ff <= 4'h8)
		else $error("match flag without timer tick");
	a_wave_has_cause: assert property (
		$changed({wave_out_a_ff, wave_out_b_ff}) |-> tick_age_ff <= 4'h8 || frc_age_ff <= 4'h3)
		else $error("waveform moved without tick or force");
	a_pwm_force_ignored: assert property (
		frc_wr && !non_pwm && tick_age_ff == 4'hF |=> $stable({wave_out_a_ff, wave_out_b_ff}) [*3])
		else $error("force acted in pwm mode");
	a_force_toggles: assert property (
		frc_wr && bus_wdata[POS_FORCE_A] && non_pwm && ctrl_sh_ff[7:6] == COM_TOGGLE
		&& pin_sh_ff[3:0] != 4'h0 |-> ##[1:3] wave_out_a_ff != $past(wave_out_a_ff))
		else $error("forced toggle did not toggle");
	a_force_level: assert property (
		frc_wr && bus_wdata[POS_FORCE_B] && non_pwm && ctrl_sh_ff[5] && pin_sh_ff[7:4] != 4'h0
		&& tick_age_ff == 4'hF |-> ##3 wave_out_b_ff == $past(ctrl_sh_ff[4], 3))
		else $error("forced set or clear wrong level");
endmodule

bind tcc_timer tcc_timer_properties i_props (
	.clock(clock), .rst(rst), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
	.bus_wdata(bus_wdata), .wave_gen_hi(wave_gen_hi), .timer_tick(timer_tick),
	.port_data(port_data), .port_dir(port_dir), .bus_rdata_ff(bus_rdata_ff),
	.pin_a_out_ff(pin_a_out_ff), .pin_a_oe_ff(pin_a_oe_ff), .pin_b_out_ff(pin_b_out_ff),
	.pin_b_oe_ff(pin_b_oe_ff), .match_a_flag_ff(match_a_flag_ff),
	.match_b_flag_ff(match_b_flag_ff), .wave_out_a_ff(wave_out_a_ff),
	.wave_out_b_ff(wave_out_b_ff));

// ### testbench/tcc_pin_model.sv
/*
 * model of the port pins beyond the block: resolves each pin's level.
 * assumes drive enables high while the block drives; no pull on the pins.
 */
`timescale 1ns/1ps
module tcc_pin_model (
	input  wire logic       clock,
	input  wire logic [7:0] pin_out,
	input  wire logic [7:0] pin_oe,
	output logic [7:0]      pin_level
);
	logic [7:0] last_ff = 8'h00;

	////////////////////////////////////////////////////////////////////////////
	// undriven pin shows the inverse of its last level, never a stale copy
	always_ff @(posedge clock) begin
		last_ff <= pin_level;
	end
	assign pin_level = (pin_out & pin_oe) | (~last_ff & ~pin_oe);
endmodule

// ### testbench/tb.sv
/*
 * self-checking bench of the timer compare output control block.
 * assumes the pin model on the pins and the bound checker.
 */
`timescale 1ns/1ps
module tb;
	import tcc_pkg::*;
	logic       clock, rst, bus_wr, bus_rd, timer_tick;
	logic [2:0] bus_addr;
	logic [7:0] bus_wdata, port_data, port_dir, bus_rdata_ff, pin_level;
	logic [1:0] wave_gen_hi;
	logic [3:0] pin_a_out_ff, pin_a_oe_ff, pin_b_out_ff, pin_b_oe_ff;
	logic       match_a_flag_ff, match_b_flag_ff, wave_out_a_ff, wave_out_b_ff;
	int         miscompares, cmp_count, flags;
	logic [1:0] modes [4] = '{2'h1, 2'h2, 2'h3, 2'h1};
	logic       wexp  [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

	tcc_timer i_dut (.clock(clock), .rst(rst), .bus_addr(bus_addr), .bus_wr(bus_wr),
		.bus_rd(bus_rd), .bus_wdata(bus_wdata), .wave_gen_hi(wave_gen_hi),
		.timer_tick(timer_tick), .port_data(port_data), .port_dir(port_dir),
		.bus_rdata_ff(bus_rdata_ff), .pin_a_out_ff(pin_a_out_ff), .pin_a_oe_ff(pin_a_oe_ff),
		.pin_b_out_ff(pin_b_out_ff), .pin_b_oe_ff(pin_b_oe_ff),
		.match_a_flag_ff(match_a_flag_ff), .match_b_flag_ff(match_b_flag_ff),
		.wave_out_a_ff(wave_out_a_ff), .wave_out_b_ff(wave_out_b_ff));
	tcc_pin_model i_pins (.clock(clock), .pin_out({pin_b_out_ff, pin_a_out_ff}),
		.pin_oe({pin_b_oe_ff, pin_a_oe_ff}), .pin_level(pin_level));

	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(negedge clock);
		bus_addr = a;
		bus_wdata = d;
		bus_wr = 1'b1;
		@(negedge clock);
		bus_wr = 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] exp, input string what);
		@(negedge clock);
		bus_addr = a;
		bus_rd = 1'b1;
		@(negedge clock);
		bus_rd = 1'b0;
		chk(what, exp, bus_rdata_ff);
	endtask
	task automatic tick(input int n);
		repeat (n) begin
			@(negedge clock);
			timer_tick = 1'b1;
			repeat (2) @(negedge clock);
			timer_tick = 1'b0;
			repeat (6) @(negedge clock);
		end
	endtask
	task automatic report_and_stop;
		$display("checks %0d miscompares %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	always @(posedge clock) begin
		if (match_a_flag_ff === 1'b1) flags <= flags + 1;
	end
	initial begin
		#200000;
		miscompares++;
		report_and_stop;
	end
	initial begin
		{rst, bus_wr, bus_rd, timer_tick} = 4'h8;
		{bus_addr, bus_wdata, wave_gen_hi} = 13'h0;
		port_data = 8'hFF;
		port_dir = 8'hFF;
		repeat (10) @(negedge clock);
		rst = 1'b0;
		rd(OFS_CTRL_A, RST_CTRL_A, "ctrl reset");
		rd(OFS_PIN_EN, RST_PIN_EN, "pin enable reset");
		rd(OFS_CNT_LO, RST_CNT[7:0], "counter low reset");
		rd(OFS_CNT_HI, RST_CNT[15:8], "counter high reset");
		wr(OFS_CTRL_A, 8'hFF);
		rd(OFS_CTRL_A, CTRL_A_WMASK, "ctrl mask");
		wr(OFS_FORCE, 8'hC0);
		rd(OFS_FORCE, 8'h00, "force read");
		wr(OFS_PIN_EN, 8'hA5);
		rd(OFS_PIN_EN, 8'hA5, "pin enable");
		repeat (3) @(negedge clock);
		chk("pins partly enabled", 8'h5A, pin_level);
		wr(OFS_PIN_EN, 8'hFF);
		for (int i = 0; i < 4; i++) begin
			wr(OFS_CTRL_A, {modes[i], modes[i], 4'h0});
			wr(OFS_FORCE, 8'hC0);
			repeat (4) @(negedge clock);
			chk("forced waves", {6'h0, wexp[i], wexp[i]}, {6'h0, wave_out_b_ff, wave_out_a_ff});
			chk("forced pins", {8{wexp[i]}}, pin_level);
		end
		chk("force flags", 8'h00, flags[7:0]);
		wr(OFS_CMP_HI, 8'h00);
		wr(OFS_CMP_A_LO, 8'h02);
		wr(OFS_CNT_HI, 8'h12);
		wr(OFS_CNT_LO, 8'h34);
		rd(OFS_CNT_LO, 8'h34, "counter low");
		rd(OFS_CNT_HI, 8'h12, "counter high");
		wr(OFS_CMP_HI, 8'h56);
		wr(OFS_CNT_LO, 8'h78);
		rd(OFS_CNT_LO, 8'h78, "shared low");
		rd(OFS_CNT_HI, 8'h56, "shared high");
		wr(OFS_CNT_HI, 8'h00);
		wr(OFS_CNT_LO, 8'h02);
		tick(1);
		chk("blocked match", 8'h00, flags[7:0]);
		wr(OFS_CNT_HI, 8'h00);
		wr(OFS_CNT_LO, 8'h00);
		tick(4);
		chk("match count", 8'h01, flags[7:0]);
		chk("toggle on match", 8'h01, {7'h0, wave_out_a_ff});
		wave_gen_hi = 2'h1;
		wr(OFS_CMP_HI, 8'h00);
		wr(OFS_CMP_A_LO, 8'h10);
		for (int m = 3; m >= 2; m--) begin
			wr(OFS_CTRL_A, {m[1:0], 6'h01});
			wr(OFS_CNT_HI, 8'h00);
			wr(OFS_CNT_LO, 8'hFE);
			tick(3);
			chk("wave at top", {7'h0, m == 2}, {7'h0, wave_out_a_ff});
			tick(20);
			chk("wave at match", {7'h0, m == 3}, {7'h0, wave_out_a_ff});
			repeat (12) @(negedge clock);
			wr(OFS_FORCE, 8'hC0);
			repeat (4) @(negedge clock);
			chk("pwm force", {7'h0, m == 3}, {7'h0, wave_out_a_ff});
		end
		wr(OFS_CTRL_A, 8'h41);
		repeat (3) @(negedge clock);
		chk("pwm code 01 pins", 8'hFF, pin_level);
		wave_gen_hi = 2'h3;
		port_data = 8'h00;
		port_dir = 8'h0F;
		wr(OFS_CTRL_A, 8'h43);
		wr(OFS_CNT_HI, 8'h00);
		wr(OFS_CNT_LO, 8'h0F);
		tick(2);
		chk("top bit toggle", 8'h01, {7'h0, wave_out_a_ff});
		chk("pin drive enables", 8'h0F, {pin_b_oe_ff, pin_a_oe_ff});
		chk("top bit pins", 8'h0F, pin_level & 8'h0F);
		report_and_stop;
	end
endmodule
